// File: src/gpiop_defines.vh
`ifndef GPIOP_DEFINES_VH
`define GPIOP_DEFINES_VH

// register byte offsets
`define GPIOP_OFF_DIR 12'h400
`define GPIOP_OFF_SENSE 12'h404
`define GPIOP_OFF_DUAL 12'h408
`define GPIOP_OFF_POL 12'h40C
`define GPIOP_OFF_MASK 12'h410
`define GPIOP_OFF_RAW 12'h414
`define GPIOP_OFF_MIS 12'h418
`define GPIOP_OFF_CLR 12'h41C
`define GPIOP_OFF_AFSEL 12'h420
`define GPIOP_OFF_DRV2 12'h500
`define GPIOP_OFF_DRV4 12'h504
`define GPIOP_OFF_DRV8 12'h508
`define GPIOP_OFF_ODR 12'h50C
`define GPIOP_OFF_PUR 12'h510
`define GPIOP_OFF_PDR 12'h514
`define GPIOP_OFF_SLR 12'h518
`define GPIOP_OFF_DEN 12'h51C
`define GPIOP_OFF_LOCK 12'h520
`define GPIOP_OFF_CR 12'h524
`define GPIOP_OFF_ID_BASE 12'hFD0

// data window: offsets 0x000..0x3FC
`define GPIOP_DATA_TOP 2'h0
// lock key and status
`define GPIOP_LOCK_KEY 32'h1ACCE551
`define GPIOP_LOCKED_VAL 32'h00000001
`define GPIOP_UNLOCKED_VAL 32'h00000000

// reset values
`define GPIOP_RST_ZERO 8'h00
`define GPIOP_RST_DRV2 8'hFF
`define GPIOP_RST_CR 8'hFF

`endif

// File: src/gpiop_port.v
// Notes on behaviour
// [RULE1] direction 0 samples pad, 1 drives
// [RULE2] write mask from address bits 9:2
// [RULE3] data decodes over 256 word slots
// [RULE4] reads return zero for masked bits
// [RULE5] one interrupt line per port
// [RULE6] edge status latched until cleared
// [RULE7] level sources hold level until seen
// [RULE8] sense, dual-edge, polarity select trigger
// [RULE9] rising, falling or both edges
// [RULE10] high or low level detection
// [RULE11] mask gates pin onto interrupt line
// [RULE12] raw status ignores the mask
// [RULE13] masked status is raw and mask
// [RULE14] write one clears status bit
// [RULE15] software masks before retuning triggers
// [RULE16] alternate select hands pin to peripheral
// [RULE17] protected select needs unlock and commit
// [RULE18] ordinary pins reset undriven
// [RULE19] debug pins reset alternate, enabled, pulled
// [RULE20] any reset restores pin defaults
// [RULE21] drive 2, 4, 8 mA; slew 8 only
// [RULE22] read-only identification registers
// [RULE23] unpadded bits ignore writes
// [RULE24] debug commit bits reset to zero
// [RULE25] sense 0 edge; polarity 1 rising/high
// [RULE26] synchronise pins, compare with previous sample
module gpiop_port #(
	parameter WIDTH = 8,
	parameter [7:0] PAD_MASK = 8'hFF,
	parameter [7:0] DEBUG_MASK = 8'h00,
	parameter [31:0] ID_WORD0 = 32'h00000011,
	parameter [31:0] ID_WORD1 = 32'h00000022
) (
	// clock, reset, enable
	input wire core_clk,
	input wire rstn,
	input wire clk_en,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	// pads
	input wire [7:0] pad_in,
	output reg [7:0] pad_out,
	output reg [7:0] pad_oe,
	// pad configuration
	output reg [7:0] pad_pull_up,
	output reg [7:0] pad_pull_down,
	output reg [7:0] pad_open_drain,
	output reg [7:0] pad_digital_en,
	output reg [7:0] pad_drive_low,
	output reg [7:0] pad_drive_mid,
	output reg [7:0] pad_drive_high,
	output reg [7:0] pad_slew_ctl,
	// peripheral alternate functions
	input wire [7:0] alt_out,
	input wire [7:0] alt_oe,
	output reg [7:0] alt_in,
	// interrupt
	output reg port_irq
);

`include "gpiop_defines.vh"

// reset lifts through two flops so no register sees it change near an edge
reg rst_s1_r;
reg rst_s2_r;
wire rst_n_i;
always @(posedge core_clk or negedge rstn) begin
	if (!rstn) begin
		rst_s1_r <= 1'b0;
		rst_s2_r <= 1'b0;
	end else begin
		rst_s1_r <= 1'b1;
		rst_s2_r <= rst_s1_r;
	end
end
assign rst_n_i = rst_s2_r;

// pin data and direction
reg [7:0] data_r;
reg [7:0] pin_direction_r;
// interrupt configuration and status
reg [7:0] irq_sense_select_r;
reg [7:0] irq_dual_edge_r;
reg [7:0] irq_polarity_r;
reg [7:0] irq_enable_mask_r;
reg [7:0] irq_raw_status_r;
// mode and commit control
reg [7:0] alt_function_select_r;
reg [7:0] commit_enable_r;
// pad configuration
reg [7:0] digital_input_enable_r;
reg [7:0] pull_up_enable_r;
reg [7:0] pull_down_enable_r;
reg [7:0] open_drain_r;
reg [7:0] slew_r;
reg [7:0] drive_low_select_r;
reg [7:0] drive_mid_select_r;
reg [7:0] drive_high_select_r;
// lock state and input pipeline
reg locked_r;
reg [7:0] sync1_r;
reg [7:0] sync2_r;
reg [7:0] prev_r;

wire acc = psel & penable;
wire wr = acc & pwrite;
wire data_hit = (paddr[11:10] == `GPIOP_DATA_TOP); // [RULE3]
wire [7:0] amask = paddr[9:2];
wire [7:0] wb = pwdata[7:0] & PAD_MASK;

assign pready = 1'b1;
assign pslverr = 1'b0;

// word match; the two byte-address bits are ignored
function hit;
	input [11:0] a;
	input [11:0] off;
	begin
		hit = (a[11:2] == off[11:2]);
	end
endfunction

// drive strengths are exclusive across the three selects; a zero write can leave none set
function [7:0] upd_onehot;
	input [7:0] mine;
	input [7:0] v;
	begin
		upd_onehot = (mine & ~PAD_MASK) | v;
	end
endfunction

// edge and level detection, one copy per pin
wire [7:0] trig;
genvar g;
generate
	for (g = 0; g < 8; g = g + 1) begin : g_trig
		reg t;
		always @* begin
			if (irq_sense_select_r[g]) // [RULE25]
				t = (sync2_r[g] == irq_polarity_r[g]); // [RULE10]
			else if (irq_dual_edge_r[g])
				t = sync2_r[g] ^ prev_r[g]; // [RULE9]
			else if (irq_polarity_r[g])
				t = sync2_r[g] & ~prev_r[g];
			else
				t = ~sync2_r[g] & prev_r[g]; // [RULE8]
		end
		// unpadded bits never raise status
		assign trig[g] = t & PAD_MASK[g];
	end
endgenerate

// clear comes only from a write to the clear register
wire [7:0] clr = (wr && hit(paddr, `GPIOP_OFF_CLR)) ? wb : 8'h00;
// set wins over a same-cycle clear
wire [7:0] raw_nxt = (irq_raw_status_r & ~clr) | trig;
wire [7:0] masked = irq_raw_status_r & irq_enable_mask_r; // [RULE13]
// debug bits need unlock and commit; the others are always writable
wire [7:0] afsel_wr_ok = locked_r ? ~DEBUG_MASK : (commit_enable_r | ~DEBUG_MASK);

always @(posedge core_clk or negedge rst_n_i) begin
	// every pin, ordinary or debug, returns to its default here
	if (!rst_n_i) begin // [RULE20]
		data_r <= `GPIOP_RST_ZERO;
		pin_direction_r <= `GPIOP_RST_ZERO;
		irq_sense_select_r <= `GPIOP_RST_ZERO;
		irq_dual_edge_r <= `GPIOP_RST_ZERO;
		irq_polarity_r <= `GPIOP_RST_ZERO;
		irq_enable_mask_r <= `GPIOP_RST_ZERO;
		irq_raw_status_r <= `GPIOP_RST_ZERO;
		alt_function_select_r <= DEBUG_MASK; // [RULE18] [RULE19]
		digital_input_enable_r <= DEBUG_MASK;
		pull_up_enable_r <= DEBUG_MASK;
		pull_down_enable_r <= `GPIOP_RST_ZERO;
		open_drain_r <= `GPIOP_RST_ZERO;
		slew_r <= `GPIOP_RST_ZERO;
		drive_low_select_r <= `GPIOP_RST_DRV2;
		drive_mid_select_r <= `GPIOP_RST_ZERO;
		drive_high_select_r <= `GPIOP_RST_ZERO;
		commit_enable_r <= `GPIOP_RST_CR & ~DEBUG_MASK; // [RULE24]
		locked_r <= 1'b1;
		sync1_r <= 8'h00;
		sync2_r <= 8'h00;
		prev_r <= 8'h00;
		prdata <= 32'h00000000;
		port_irq <= 1'b0;
	// clock enable low freezes every register but the reset synchroniser, pad synchronisers included
	end else if (clk_en) begin
		sync1_r <= pad_in;
		sync2_r <= sync1_r; // [RULE26]
		prev_r <= sync2_r;
		// set wins over a same-cycle clear
		irq_raw_status_r <= raw_nxt; // [RULE6] [RULE12] [RULE14]
		port_irq <= |(raw_nxt & irq_enable_mask_r); // [RULE5] [RULE11]
		// input bits capture pad level, output bits hold written value
		data_r <= (data_r & pin_direction_r) | (sync2_r & ~pin_direction_r & PAD_MASK); // [RULE1]
		if (wr && data_hit)
			data_r <= (data_r & ~(amask & pin_direction_r & PAD_MASK)) |
				(wb & amask & pin_direction_r) |
				(sync2_r & ~pin_direction_r & PAD_MASK); // [RULE2] [RULE23]
		if (wr) begin
			if (hit(paddr, `GPIOP_OFF_DIR))
				pin_direction_r <= wb;
			if (hit(paddr, `GPIOP_OFF_SENSE))
				irq_sense_select_r <= wb;
			if (hit(paddr, `GPIOP_OFF_DUAL))
				irq_dual_edge_r <= wb;
			if (hit(paddr, `GPIOP_OFF_POL))
				irq_polarity_r <= wb;
			if (hit(paddr, `GPIOP_OFF_MASK))
				irq_enable_mask_r <= wb;
			if (hit(paddr, `GPIOP_OFF_AFSEL))
				alt_function_select_r <= (alt_function_select_r & ~afsel_wr_ok) |
					(wb & afsel_wr_ok); // [RULE17]
			if (hit(paddr, `GPIOP_OFF_DRV2)) begin
				drive_low_select_r <= upd_onehot(drive_low_select_r, wb); // [RULE21]
				drive_mid_select_r <= drive_mid_select_r & ~wb;
				drive_high_select_r <= drive_high_select_r & ~wb;
			end
			if (hit(paddr, `GPIOP_OFF_DRV4)) begin
				drive_mid_select_r <= upd_onehot(drive_mid_select_r, wb);
				drive_low_select_r <= drive_low_select_r & ~wb;
				drive_high_select_r <= drive_high_select_r & ~wb;
			end
			if (hit(paddr, `GPIOP_OFF_DRV8)) begin
				drive_high_select_r <= upd_onehot(drive_high_select_r, wb);
				drive_low_select_r <= drive_low_select_r & ~wb;
				drive_mid_select_r <= drive_mid_select_r & ~wb;
			end
			if (hit(paddr, `GPIOP_OFF_ODR))
				open_drain_r <= wb;
			if (hit(paddr, `GPIOP_OFF_PUR)) begin
				pull_up_enable_r <= wb;
				pull_down_enable_r <= pull_down_enable_r & ~wb;
			end
			if (hit(paddr, `GPIOP_OFF_PDR)) begin
				pull_down_enable_r <= wb;
				pull_up_enable_r <= pull_up_enable_r & ~wb;
			end
			if (hit(paddr, `GPIOP_OFF_SLR))
				slew_r <= wb;
			if (hit(paddr, `GPIOP_OFF_DEN))
				digital_input_enable_r <= wb;
			// any value other than the key locks again
			if (hit(paddr, `GPIOP_OFF_LOCK))
				locked_r <= (pwdata != `GPIOP_LOCK_KEY);
			if (hit(paddr, `GPIOP_OFF_CR) && !locked_r)
				commit_enable_r <= (commit_enable_r & ~DEBUG_MASK) | (wb & DEBUG_MASK);
		end
		// read data registered while setup phase is seen
		if (psel && !penable && !pwrite) begin
			// unmapped addresses read as zero
			prdata <= 32'h00000000;
			if (data_hit)
				prdata <= {24'h000000, data_r & amask & PAD_MASK}; // [RULE4]
			else if (hit(paddr, `GPIOP_OFF_DIR))
				prdata <= {24'h000000, pin_direction_r};
			else if (hit(paddr, `GPIOP_OFF_SENSE))
				prdata <= {24'h000000, irq_sense_select_r};
			else if (hit(paddr, `GPIOP_OFF_DUAL))
				prdata <= {24'h000000, irq_dual_edge_r};
			else if (hit(paddr, `GPIOP_OFF_POL))
				prdata <= {24'h000000, irq_polarity_r};
			else if (hit(paddr, `GPIOP_OFF_MASK))
				prdata <= {24'h000000, irq_enable_mask_r};
			else if (hit(paddr, `GPIOP_OFF_RAW))
				prdata <= {24'h000000, irq_raw_status_r};
			else if (hit(paddr, `GPIOP_OFF_MIS))
				prdata <= {24'h000000, masked};
			else if (hit(paddr, `GPIOP_OFF_AFSEL))
				prdata <= {24'h000000, alt_function_select_r};
			else if (hit(paddr, `GPIOP_OFF_DRV2))
				prdata <= {24'h000000, drive_low_select_r};
			else if (hit(paddr, `GPIOP_OFF_DRV4))
				prdata <= {24'h000000, drive_mid_select_r};
			else if (hit(paddr, `GPIOP_OFF_DRV8))
				prdata <= {24'h000000, drive_high_select_r};
			else if (hit(paddr, `GPIOP_OFF_ODR))
				prdata <= {24'h000000, open_drain_r};
			else if (hit(paddr, `GPIOP_OFF_PUR))
				prdata <= {24'h000000, pull_up_enable_r};
			else if (hit(paddr, `GPIOP_OFF_PDR))
				prdata <= {24'h000000, pull_down_enable_r};
			else if (hit(paddr, `GPIOP_OFF_SLR))
				prdata <= {24'h000000, slew_r};
			else if (hit(paddr, `GPIOP_OFF_DEN))
				prdata <= {24'h000000, digital_input_enable_r};
			else if (hit(paddr, `GPIOP_OFF_LOCK))
				prdata <= locked_r ? `GPIOP_LOCKED_VAL : `GPIOP_UNLOCKED_VAL;
			else if (hit(paddr, `GPIOP_OFF_CR))
				prdata <= {24'h000000, commit_enable_r};
			// identification words are fixed by parameter
			else if (hit(paddr, `GPIOP_OFF_ID_BASE))
				prdata <= ID_WORD0; // [RULE22]
			else if (hit(paddr, `GPIOP_OFF_ID_BASE + 12'h004))
				prdata <= ID_WORD1;
		end
	end
end

// pad muxing, one copy per pin
wire [7:0] pad_out_w;
wire [7:0] pad_oe_w;
generate
	for (g = 0; g < 8; g = g + 1) begin : g_pad
		wire out_sel = alt_function_select_r[g] ? alt_out[g] : data_r[g]; // [RULE16]
		wire oe_sel = alt_function_select_r[g] ? alt_oe[g] : pin_direction_r[g];
		// open drain only pulls low; a high is left to the pull-up
		assign pad_out_w[g] = open_drain_r[g] ? 1'b0 : out_sel;
		assign pad_oe_w[g] = (open_drain_r[g] ? oe_sel & ~out_sel : oe_sel) & PAD_MASK[g];
	end
endgenerate

always @* begin
	pad_out = pad_out_w;
	pad_oe = pad_oe_w;
	// peripheral sees the synchronised level only with input enabled
	alt_in = sync2_r & digital_input_enable_r;
	// pad configuration straight from registers, unpadded bits held off
	pad_pull_up = pull_up_enable_r & PAD_MASK;
	pad_pull_down = pull_down_enable_r & PAD_MASK;
	pad_open_drain = open_drain_r & PAD_MASK;
	pad_digital_en = digital_input_enable_r & PAD_MASK;
	pad_drive_low = drive_low_select_r & PAD_MASK;
	pad_drive_mid = drive_mid_select_r & PAD_MASK;
	pad_drive_high = drive_high_select_r & PAD_MASK;
	// slew only meaningful at high drive
	pad_slew_ctl = slew_r & drive_high_select_r & PAD_MASK; // [RULE21]
end

endmodule // gpiop_port

// File: testbench/gpiop_chk.sv
module gpiop_chk #(
	parameter [7:0] PAD_MASK = 8'hFF,
	parameter [7:0] DEBUG_MASK = 8'h00
) (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// bus
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire pready,
	input wire [31:0] prdata,
	// pads and interrupt
	input wire [7:0] pad_pull_up,
	input wire [7:0] pad_pull_down,
	input wire [7:0] pad_digital_en,
	input wire [7:0] pad_drive_low,
	input wire [7:0] pad_drive_mid,
	input wire [7:0] pad_drive_high,
	input wire port_irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_wr; psel && penable && pwrite; endsequence
	sequence s_rd; psel && penable && !pwrite; endsequence
	property p_ready; pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_rd_mask; s_rd ##0 paddr[11:10] == 2'h0 |-> (prdata[7:0] & ~paddr[9:2]) == 8'h00;
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("masked data bit set");
	property p_rd_upper; s_rd |-> prdata[31:8] == 24'h000000; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	property p_unmapped; s_rd ##0 paddr == 12'h600 |-> prdata == 32'h00000000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rst; $rose(rstn) |-> pad_pull_up == DEBUG_MASK && pad_digital_en == DEBUG_MASK
		&& pad_pull_down == 8'h00 && pad_drive_low == (8'hFF & PAD_MASK); endproperty
	a_rst: assert property (p_rst) else $error("pad reset state wrong");
	property p_drv; ((pad_drive_low & pad_drive_mid) | (pad_drive_low & pad_drive_high)
		| (pad_drive_mid & pad_drive_high)) == 8'h00; endproperty
	a_drv: assert property (p_drv) else $error("two drive strengths on one pin");
	property p_pull; (pad_pull_up & pad_pull_down) == 8'h00; endproperty
	a_pull: assert property (p_pull) else $error("pull up and down together");
	property p_irq_fall; $fell(port_irq) |-> $past(psel && penable && pwrite)
		|| $past(psel && penable && pwrite, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
	c_wr: cover property (s_wr);
endmodule // gpiop_chk

bind gpiop_port gpiop_chk #(.PAD_MASK(PAD_MASK), .DEBUG_MASK(DEBUG_MASK)) i_gpiop_chk (
	.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .prdata(prdata), .pad_pull_up(pad_pull_up),
	.pad_pull_down(pad_pull_down), .pad_digital_en(pad_digital_en),
	.pad_drive_low(pad_drive_low), .pad_drive_mid(pad_drive_mid),
	.pad_drive_high(pad_drive_high), .port_irq(port_irq));

// File: testbench/gpiop_pad_model.sv
module gpiop_pad_model (
	// design side
	input wire core_clk,
	input wire [7:0] pad_out,
	input wire [7:0] pad_oe,
	input wire [7:0] pad_pull_up,
	input wire [7:0] pad_pull_down,
	// bench side
	input wire [7:0] ext_val,
	input wire [7:0] ext_en,
	output wire [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// undriven pins with no pull wander so a stale level is never read as data
	logic [7:0] flt_r = 8'h55;
	always @(posedge core_clk) begin
		flt_r <= ~flt_r;
	end
	// external source holds its level until the bench moves it
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pull_up | (~pad_pull_down & flt_r)));
endmodule // gpiop_pad_model

// File: testbench/testbench.sv
`include "gpiop_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [31:0] ALL = 32'hFFFFFFFF;
	localparam [31:0] ID0 = 32'h000000A5; // arbitrary
	logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [7:0] alt_out = 8'h00, alt_oe = 8'h00, ext_val = 8'h00, ext_en = 8'hFF;
	logic clk_en = 1'b1;
	wire pready, pslverr, port_irq;
	wire [31:0] prdata;
	wire [7:0] pad_in, pad_out, pad_oe, pu, pd, od, den, dl, dm, dh, slw, alt_in;
	int error_cnt = 0, cmp_count = 0;
	logic [5:0] cases [9] = '{6'h0B, 6'h0C, 6'h05, 6'h02, 6'h13, 6'h1D, 6'h2B, 6'h21, 6'h28};
	always #5 core_clk = ~core_clk;
	gpiop_port #(.PAD_MASK(8'hBF), .DEBUG_MASK(8'h80), .ID_WORD0(ID0)) i_gpiop_port (
		.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_up(pu), .pad_pull_down(pd), .pad_open_drain(od), .pad_digital_en(den),
		.pad_drive_low(dl), .pad_drive_mid(dm), .pad_drive_high(dh), .pad_slew_ctl(slw),
		.alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .port_irq(port_irq));
	gpiop_pad_model i_gpiop_pad_model (.core_clk(core_clk), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pull_up(pu), .pad_pull_down(pd), .ext_val(ext_val),
		.ext_en(ext_en), .pad_in(pad_in));
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input [31:0] seen, input [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input wr, input [11:0] a, input [31:0] d, output [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 50) begin
			error_cnt++;
			end_of_test();
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input [11:0] a, input [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input [11:0] a, input [31:0] m, input [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h00000000, q);
		chk(q & m, e);
		chk(pslverr, 32'h00000000);
	endtask
	task automatic do_reset;
		rstn <= 1'b0;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(pu, 8'h80);
		chk(den, 8'h80);
		chk(od | pd | dm | dh, 8'h00);
		rd(`GPIOP_OFF_AFSEL, ALL, 32'h00000080);
	endtask
	task automatic t_reset;
		rd(`GPIOP_OFF_DIR, ALL, 32'h00000000);
		rd(`GPIOP_OFF_PUR, ALL, 32'h00000080);
		rd(`GPIOP_OFF_PDR, ALL, 32'h00000000);
		rd(`GPIOP_OFF_CR, ALL, 32'h0000007F);
		// bit 6 has no pad, so its read value is not defined
		rd(`GPIOP_OFF_DRV2, 32'h000000BF, 32'h000000BF);
		rd(`GPIOP_OFF_LOCK, ALL, `GPIOP_LOCKED_VAL);
		rd(`GPIOP_OFF_ID_BASE, ALL, ID0);
		rd(12'h600, ALL, 32'h00000000);
	endtask
	task automatic t_data;
		wr(`GPIOP_OFF_DEN, 32'h000000FF);
		wr(`GPIOP_OFF_DIR, 32'h000000FF);
		wr(12'h3FC, 32'h00000000);
		wr(12'h098, 32'h000000EB);
		chk(pad_oe & 8'h3F, 8'h3F);
		chk(pad_out & 8'h3F, 8'h22);
		rd(12'h0C4, ALL, 32'h00000020);
		rd(12'h0FC, ALL, 32'h00000022);
		ext_val <= 8'h15;
		wr(`GPIOP_OFF_DIR, 32'h00000000);
		repeat (3) @(posedge core_clk);
		rd(12'h0FC, ALL, 32'h00000015);
		chk(alt_in & 8'h3F, 8'h15);
		// frozen clock enable: a new pad level must not get in
		clk_en <= 1'b0;
		ext_val <= 8'h2A;
		repeat (4) @(posedge core_clk);
		chk(alt_in & 8'h3F, 8'h15);
		clk_en <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(alt_in & 8'h3F, 8'h2A);
		ext_val <= 8'h15;
		repeat (4) @(posedge core_clk);
	endtask
	// bits: sense, dual, polarity, start level, end level, expected raw
	task automatic t_trig(input [5:0] c);
		wr(`GPIOP_OFF_MASK, 32'h00000000);
		wr(`GPIOP_OFF_SENSE, {31'h0, c[5]});
		wr(`GPIOP_OFF_DUAL, {31'h0, c[4]});
		wr(`GPIOP_OFF_POL, {31'h0, c[3]});
		ext_val[0] <= c[2];
		repeat (4) @(posedge core_clk);
		wr(`GPIOP_OFF_CLR, 32'h000000FF);
		ext_val[0] <= c[1];
		repeat (4) @(posedge core_clk);
		rd(`GPIOP_OFF_RAW, 32'h00000001, {31'h0, c[0]});
	endtask
	task automatic t_irq;
		int n;
		wr(`GPIOP_OFF_SENSE, 32'h00000000);
		wr(`GPIOP_OFF_POL, 32'h00000006);
		ext_val[2:1] <= 2'b00;
		wr(`GPIOP_OFF_CLR, 32'h000000FF);
		wr(`GPIOP_OFF_MASK, 32'h00000002);
		ext_val[2:1] <= 2'b11;
		for (n = 0; n < 20 && port_irq !== 1'b1; n++)
			@(posedge core_clk);
		chk(port_irq, 1'b1);
		rd(`GPIOP_OFF_MIS, 32'h00000006, 32'h00000002);
		rd(`GPIOP_OFF_RAW, 32'h00000006, 32'h00000006);
		ext_val[1] <= 1'b0;
		wr(`GPIOP_OFF_CLR, 32'h00000004);
		repeat (4) @(posedge core_clk);
		chk(port_irq, 1'b1);
		rd(`GPIOP_OFF_RAW, 32'h00000006, 32'h00000002);
		wr(`GPIOP_OFF_CLR, 32'h00000002);
		@(posedge core_clk);
		chk(port_irq, 1'b0);
	endtask
	task automatic t_lock;
		wr(`GPIOP_OFF_AFSEL, 32'h00000000);
		rd(`GPIOP_OFF_AFSEL, ALL, 32'h00000080);
		wr(`GPIOP_OFF_LOCK, `GPIOP_LOCK_KEY);
		wr(`GPIOP_OFF_CR, 32'h000000FF);
		wr(`GPIOP_OFF_AFSEL, 32'h00000001);
		rd(`GPIOP_OFF_AFSEL, ALL, 32'h00000001);
		alt_oe <= 8'h01;
		alt_out <= 8'h01;
		@(posedge core_clk);
		@(negedge core_clk);
		chk({pad_oe[0], pad_out[0]}, 2'b11);
		wr(`GPIOP_OFF_LOCK, 32'h00000000);
		rd(`GPIOP_OFF_LOCK, ALL, `GPIOP_LOCKED_VAL);
		wr(`GPIOP_OFF_DRV8, 32'h00000001);
		rd(`GPIOP_OFF_DRV2, 32'h0000003F, 32'h0000003E);
		chk(dh & 8'h01, 8'h01);
		// slew reaches the pad only where high drive is chosen
		wr(`GPIOP_OFF_SLR, 32'h00000003);
		chk(slw, 8'h01);
		chk(dm & 8'h03, 8'h00);
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		do_reset();
		t_reset();
		t_data();
		foreach (cases[i])
			t_trig(cases[i]);
		t_irq();
		t_lock();
		do_reset();
		end_of_test();
	end
endmodule // testbench
